/* verilog/usb_bulk_in_endpoint_fifo.sv */
// bulk in endpoint: two bank fifo toggle, nak control, dma request
// Functional notes
// R1 - nak control resets to 0 (answer nak); 1 means data is sent on in tokens.
// R2 - nak control is set only when the sie side bank cannot take more data.
// R3 - banks toggle only when the cpu bank is full or data end is set and the sie count is 0.
// R4 - a toggle sets nak control and the sent bank is held until sent correctly.
// R5 - processor writes that fill the cpu bank and toggle set nak control and start sending.
// R6 - a dma fill with dma end enable 0 does not toggle until data end is set.
// R7 - setting data end toggles the banks and sets nak control together.
// R8 - clearing the buffer clears nak control at once.
// R9 - enabling dma while processor writes are under way raises the request at once.
// R10 - after 64 dma bytes the request drops and returns on the next toggle unless masked.
// R11 - while nak control is 0 no data goes out on in tokens.
// R12 - terminal count drops and masks the request until firmware unmasks it.
// R13 - cpu reset sets the five interrupt clear registers to ff and the rest to 00; the code holds only one of them, intr_clear.
// R14 - usb bus reset clears only the configured flag and the alt setting status.
// R15 - dma request is asserted only while the cpu bank can take data and is unmasked.
`timescale 1ns/1ps
`include "bulk_in_ep_cfg.svh"
module usb_bulk_in_endpoint_fifo #(
    parameter int DEPTH = `EP_FIFO_BYTES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic bus_reset,
    input wire logic buf_wr,
    input wire bulk_in_ep_pkg::byte_t buf_wr_data,
    input wire logic dma_mode,
    input wire logic dma_wr,
    input wire logic dma_terminal_count,
    input wire logic dma_unmask,
    input wire logic buf_clear,
    input wire logic bulk_in_data_end_set,
    input wire logic bulk_in_dma_end_enable,
    input wire logic in_token,
    input wire logic tx_ack,
    input wire logic tx_byte_take,
    input wire logic configured_set,
    input wire bulk_in_ep_pkg::byte_t alt_setting_wr_data,
    input wire logic alt_setting_wr,
    output logic bulk_in_nak_ctrl,
    output logic dma_req,
    output logic nak_out,
    output logic tx_active,
    output bulk_in_ep_pkg::byte_t tx_data,
    output logic tx_last,
    output bulk_in_ep_pkg::count_t cpu_count,
    output bulk_in_ep_pkg::count_t sie_count,
    output bulk_in_ep_pkg::byte_t device_state_reg,
    output bulk_in_ep_pkg::byte_t alt_setting_status_reg,
    output bulk_in_ep_pkg::byte_t interrupt_clear_reg_first,
    output logic bulk_in_data_end
);
    import bulk_in_ep_pkg::*;
    localparam count_t FULL = count_t'(DEPTH);
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT_ACK} tx_state_t;
    typedef struct packed {
        logic nak;
        logic cpu_bank;
        count_t cpu_cnt;
        count_t sie_cnt;
        count_t sie_ptr;
        logic data_end;
        logic dma_filled;
        logic dma_mask;
        logic dma_hold;
        tx_state_t tx;
        logic tx_act;
        logic tx_lst;
        byte_t dev_state;
        byte_t alt_status;
        byte_t intr_clear;
    } ep_state_t;
    ep_state_t s_reg;
    ep_state_t s_next;
    logic cpu_full;
    logic wr_any;
    logic toggle;
    bank_if bk ();

    assign cpu_full = (s_reg.cpu_cnt == FULL);
    assign wr_any = (buf_wr | (dma_wr & dma_req)) & ~cpu_full;
    // toggle needs a full bank or data end, plus an empty sie bank
    assign toggle = ((cpu_full & ~s_reg.dma_filled) | s_reg.data_end)
        & (s_reg.cpu_cnt != '0 | s_reg.data_end) & (s_reg.sie_cnt == '0)
        & (s_reg.tx == TX_IDLE); // [R3] [R6]

    always_comb begin
        s_next = s_reg;
        s_next.tx_lst = 1'b0;
        if (wr_any) begin
            s_next.cpu_cnt = s_reg.cpu_cnt + 7'h01;
            s_next.dma_filled = dma_wr & ~buf_wr & ~bulk_in_dma_end_enable
                & (s_reg.cpu_cnt + 7'h01 == FULL); // [R6]
        end
        if (dma_wr & dma_req & (s_reg.cpu_cnt + 7'h01 == FULL)) begin
            s_next.dma_hold = 1'b1; // [R10]
        end
        if (dma_unmask) begin
            s_next.dma_mask = 1'b0; // [R12]
        end
        // terminal count in the unmask cycle still masks: set wins
        if (dma_terminal_count & dma_mode) begin
            s_next.dma_mask = 1'b1; // [R12]
        end
        if (toggle) begin
            s_next.cpu_bank = ~s_reg.cpu_bank;
            s_next.sie_cnt = s_reg.cpu_cnt;
            s_next.sie_ptr = '0;
            s_next.cpu_cnt = '0;
            s_next.data_end = 1'b0;
            s_next.dma_filled = 1'b0;
            s_next.dma_hold = 1'b0; // [R10]
            // sie bank now loaded and unable to take more
            s_next.nak = 1'b1; // [R4] [R5] [R7]
        end
        unique case (s_reg.tx)
            TX_IDLE: begin
                if (in_token & s_reg.nak) begin
                    s_next.tx = TX_SEND; // [R11]
                    s_next.tx_act = 1'b1;
                end
            end
            TX_SEND: begin
                if (tx_byte_take | s_reg.sie_cnt == '0) begin
                    if (s_reg.sie_ptr + 7'h01 >= s_reg.sie_cnt) begin
                        s_next.tx = TX_WAIT_ACK;
                        s_next.tx_act = 1'b0;
                        s_next.tx_lst = 1'b1;
                    end else begin
                        s_next.sie_ptr = s_reg.sie_ptr + 7'h01;
                    end
                end
            end
            TX_WAIT_ACK: begin
                // bank kept for retry until the host acknowledges
                if (tx_ack) begin
                    s_next.sie_cnt = '0; // [R4]
                    s_next.tx = TX_IDLE;
                    if (~toggle) begin
                        s_next.nak = 1'b0; // [R2]
                    end
                end else if (in_token) begin
                    s_next.sie_ptr = '0;
                    s_next.tx = TX_SEND;
                    s_next.tx_act = 1'b1;
                end
            end
        endcase
        if (buf_clear) begin
            s_next.nak = 1'b0; // [R8]
            s_next.cpu_cnt = '0;
            s_next.sie_cnt = '0;
            s_next.data_end = 1'b0;
            s_next.dma_filled = 1'b0;
            s_next.dma_hold = 1'b0;
            s_next.tx = TX_IDLE;
            s_next.tx_act = 1'b0;
        end
        // set after the clears so a data end strobe is never lost
        if (bulk_in_data_end_set) begin
            s_next.data_end = 1'b1; // [R7]
        end
        if (configured_set) begin
            s_next.dev_state[`CONFIGURED_BIT] = 1'b1;
        end
        if (alt_setting_wr) begin
            s_next.alt_status = alt_setting_wr_data;
        end
        if (bus_reset) begin
            s_next.dev_state[`CONFIGURED_BIT] = 1'b0; // [R14]
            s_next.alt_status = `REG_RESET; // [R14]
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_reg <= '0; // [R1] [R13]
            s_reg.tx <= TX_IDLE;
            s_reg.dev_state <= `REG_RESET;
            s_reg.alt_status <= `REG_RESET;
            s_reg.intr_clear <= `INTR_CLEAR_RESET; // [R13]
        end else begin
            s_reg <= s_next;
        end
    end

    // request is combinational so enabling dma mid-write asks at once
    assign dma_req = dma_mode & ~s_reg.dma_mask & ~s_reg.dma_hold & ~cpu_full
        & ~s_reg.data_end; // [R9] [R15]

    assign bk.wr_en = wr_any;
    assign bk.wr_data = buf_wr_data;
    assign bk.wr_bank = s_reg.cpu_bank;
    assign bk.rd_en = s_next.tx_act;
    assign bk.rd_bank = ~s_reg.cpu_bank;
    assign bk.rd_addr = s_next.sie_ptr[5:0];

    bank_store #(.DEPTH(DEPTH)) u_store (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_clear(toggle | buf_clear),
        .bk(bk)
    );

    assign bulk_in_nak_ctrl = s_reg.nak;
    assign nak_out = in_token & ~s_reg.nak & (s_reg.tx == TX_IDLE); // [R11]
    assign tx_active = s_reg.tx_act;
    assign tx_data = bk.rd_data;
    assign tx_last = s_reg.tx_lst;
    assign cpu_count = s_reg.cpu_cnt;
    assign sie_count = s_reg.sie_cnt;
    assign device_state_reg = s_reg.dev_state;
    assign alt_setting_status_reg = s_reg.alt_status;
    assign interrupt_clear_reg_first = s_reg.intr_clear;
    assign bulk_in_data_end = s_reg.data_end;
endmodule

/* verilog/bulk_in_ep_cfg.svh */
// constants for the bulk in endpoint block
`ifndef BULK_IN_EP_CFG_SVH
`define BULK_IN_EP_CFG_SVH
`define EP_FIFO_BYTES 64
`define EP_CNT_W 7
`define INTR_CLEAR_RESET 8'hff
`define REG_RESET 8'h00
`define CONFIGURED_BIT 2
`endif

/* verilog/bulk_in_ep_pkg.sv */
// types shared by the bulk in endpoint files
package bulk_in_ep_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] count_t;
endpackage

/* verilog/bank_if.sv */
// bank side signals between endpoint control and the bank store
`timescale 1ns/1ps
interface bank_if;
    logic wr_en;
    logic [7:0] wr_data;
    logic wr_bank;
    logic rd_en;
    logic rd_bank;
    logic [5:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_data, output wr_bank, output rd_en,
        output rd_bank, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_data, input wr_bank, input rd_en,
        input rd_bank, input rd_addr, output rd_data);
endinterface

/* verilog/bank_store.sv */
// two banks of 64 byte storage with write pointer per bank
`timescale 1ns/1ps
`include "bulk_in_ep_cfg.svh"
module bank_store #(
    parameter int DEPTH = `EP_FIFO_BYTES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_clear,
    bank_if.store bk
);
    import bulk_in_ep_pkg::*;
    typedef struct packed {
        logic [1:0][5:0] wptr;
        logic [7:0] rd_data;
    } store_state_t;
    logic [7:0] mem_reg [2][DEPTH];
    store_state_t s_reg;
    store_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (bk.wr_en) begin
            s_next.wptr[bk.wr_bank] = s_reg.wptr[bk.wr_bank] + 6'h01;
        end
        if (wr_clear) begin
            s_next.wptr[bk.wr_bank] = 6'h00;
        end
        // read port only moves while a packet is being sent
        if (bk.rd_en) begin
            s_next.rd_data = mem_reg[bk.rd_bank][bk.rd_addr];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // memory has no reset; contents are only read after being written
    always_ff @(posedge clk_sys) begin
        if (bk.wr_en) begin
            mem_reg[bk.wr_bank][s_reg.wptr[bk.wr_bank]] <= bk.wr_data;
        end
    end

    assign bk.rd_data = s_reg.rd_data;
endmodule

/* bench/bulk_in_host_model.sv */
// host side: in tokens, byte takes and acks
`timescale 1ns/1ps
module bulk_in_host_model (
    input wire logic clk_sys,
    input wire logic poll,
    input wire logic slow,
    input wire logic tx_active,
    input wire logic tx_last,
    output logic in_token,
    output logic tx_byte_take,
    output logic tx_ack
);
    logic ph = 0;
    initial {in_token, tx_byte_take, tx_ack} = 3'h0;
    always @(posedge clk_sys) begin
        ph <= ~ph;
        // no new token while a packet is under way
        in_token <= poll && !tx_active && !in_token;
        tx_byte_take <= tx_active && !tx_last && (!slow || ph);
        tx_ack <= tx_last;
    end
endmodule

/* bench/usb_bulk_in_endpoint_fifo_asserts.sv */
// port checker for the bulk in endpoint
`timescale 1ns/1ps
module bulk_in_ep_chk #(
    parameter int DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic buf_clear,
    input wire logic dma_mode,
    input wire logic dma_terminal_count,
    input wire logic bulk_in_dma_end_enable,
    input wire logic bulk_in_data_end_set,
    input wire logic in_token,
    input wire logic tx_ack,
    input wire logic bus_reset,
    input wire logic bulk_in_nak_ctrl,
    input wire logic dma_req,
    input wire logic nak_out,
    input wire logic tx_active,
    input wire logic tx_last,
    input wire logic bulk_in_data_end,
    input wire bulk_in_ep_pkg::count_t cpu_count,
    input wire bulk_in_ep_pkg::count_t sie_count,
    input wire bulk_in_ep_pkg::byte_t device_state_reg,
    input wire bulk_in_ep_pkg::byte_t alt_setting_status_reg
);
    import bulk_in_ep_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    nak_ans_a: assert property (in_token && !bulk_in_nak_ctrl |-> nak_out)
        else $error("token not answered with nak");
    no_send_a: assert property (in_token && !bulk_in_nak_ctrl && !tx_active
        |=> !tx_active)
        else $error("sent while nak control low");
    tog_cnt_a: assert property ($rose(bulk_in_nak_ctrl) |-> $past(sie_count) == 0)
        else $error("toggle with sie bank busy");
    nak_fall_a: assert property ($fell(bulk_in_nak_ctrl)
        |-> $past(tx_ack) || $past(buf_clear))
        else $error("nak control dropped early");
    clr_nak_a: assert property (buf_clear |=> !bulk_in_nak_ctrl)
        else $error("clear kept nak control");
    full_tog_a: assert property (cpu_count == DEPTH && sie_count == 0 && !dma_mode
        && !buf_clear |=> bulk_in_nak_ctrl)
        else $error("full bank did not toggle");
    dma_hold_a: assert property (dma_mode && !bulk_in_dma_end_enable && !bulk_in_data_end
        && !bulk_in_data_end_set && cpu_count == DEPTH |=> !$rose(bulk_in_nak_ctrl))
        else $error("dma fill toggled early");
    req_full_a: assert property (cpu_count == DEPTH |-> !dma_req)
        else $error("request with full bank");
    tc_mask_a: assert property (dma_mode && dma_terminal_count |=> !dma_req)
        else $error("request after terminal count");
    bus_rst_a: assert property (bus_reset
        |=> !device_state_reg[2] && alt_setting_status_reg == 8'h00)
        else $error("bus reset values wrong");
    cover property ($rose(bulk_in_nak_ctrl));
    cover property (tx_last);
    cover property (dma_mode && dma_terminal_count);
endmodule
bind usb_bulk_in_endpoint_fifo bulk_in_ep_chk #(.DEPTH(DEPTH)) u_chk (.clk_sys, .reset,
    .buf_clear, .dma_mode, .dma_terminal_count, .bulk_in_dma_end_enable, .bulk_in_data_end_set,
    .in_token, .tx_ack, .bus_reset, .bulk_in_nak_ctrl, .dma_req, .nak_out, .tx_active, .tx_last,
    .bulk_in_data_end, .cpu_count, .sie_count, .device_state_reg, .alt_setting_status_reg);

/* bench/tb_usb_bulk_in_endpoint_fifo.sv */
// testbench for the bulk in endpoint
`timescale 1ns/1ps
module tb_usb_bulk_in_endpoint_fifo;
    import bulk_in_ep_pkg::*;
    logic clk_sys = 0, reset = 1, bus_reset = 0, buf_wr = 0, dma_mode = 0, dma_wr = 0;
    logic dma_terminal_count = 0, dma_unmask = 0, buf_clear = 0, bulk_in_data_end_set = 0;
    logic bulk_in_dma_end_enable = 0, configured_set = 0, alt_setting_wr = 0, poll = 0, slow = 0;
    byte_t buf_wr_data = 8'h00, alt_setting_wr_data = 8'h00;
    logic in_token, tx_ack, tx_byte_take, bulk_in_nak_ctrl, dma_req, nak_out, tx_active, tx_last;
    logic bulk_in_data_end;
    byte_t tx_data, device_state_reg, alt_setting_status_reg, interrupt_clear_reg_first;
    count_t cpu_count, sie_count;
    int err_count = 0, num_checks = 0;
    int take_idx = 0, pkt_len = 0;
    always #50 clk_sys = ~clk_sys;
    usb_bulk_in_endpoint_fifo u_dut (.clk_sys, .reset, .bus_reset, .buf_wr, .buf_wr_data,
        .dma_mode, .dma_wr, .dma_terminal_count, .dma_unmask, .buf_clear, .bulk_in_data_end_set,
        .bulk_in_dma_end_enable, .in_token, .tx_ack, .tx_byte_take, .configured_set,
        .alt_setting_wr_data, .alt_setting_wr, .bulk_in_nak_ctrl, .dma_req, .nak_out, .tx_active,
        .tx_data, .tx_last, .cpu_count, .sie_count, .device_state_reg, .alt_setting_status_reg,
        .interrupt_clear_reg_first, .bulk_in_data_end);
    bulk_in_host_model u_host (.clk_sys, .poll, .slow, .tx_active, .tx_last, .in_token,
        .tx_byte_take, .tx_ack);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // bytes go out in written order, one per accepted take
    always @(posedge clk_sys) begin
        if (tx_last) begin
            chk(take_idx[7:0], pkt_len[7:0]);
            take_idx <= 0;
        end else if (tx_active && tx_byte_take) begin
            chk(tx_data, take_idx[7:0]);
            take_idx <= take_idx + 1;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys) buf_wr <= 1;
            buf_wr_data <= i[7:0];
        end
        @(posedge clk_sys) buf_wr <= 0;
    endtask
    task automatic drain;
        @(posedge clk_sys) poll <= 1;
        for (int i = 0; i < 400 && bulk_in_nak_ctrl; i++) tick(1);
        @(posedge clk_sys) poll <= 0;
        tick(0);
        chk({1'b0, sie_count}, 8'h00);
    endtask
    task automatic t_pio;
        pkt_len = 64;
        wr(64);
        tick(1);
        chk(bulk_in_nak_ctrl, 1);
        chk({1'b0, sie_count}, 8'h40);
        drain();
        $display("pio done");
    endtask
    task automatic t_short;
        pkt_len = 3;
        wr(3);
        @(posedge clk_sys) poll <= 1;
        for (int i = 0; i < 20 && in_token !== 1; i++) tick(1);
        chk(nak_out, 1);
        tick(1);
        chk(tx_active, 0);
        poll <= 0;
        @(posedge clk_sys) bulk_in_data_end_set <= 1;
        @(posedge clk_sys) bulk_in_data_end_set <= 0;
        tick(0);
        chk(bulk_in_data_end, 1);
        tick(1);
        chk(bulk_in_nak_ctrl, 1);
        chk(bulk_in_data_end, 0);
        chk({1'b0, sie_count}, 8'h03);
        slow <= 1;
        drain();
        $display("short done");
    endtask
    task automatic t_dma;
        wr(1);
        @(posedge clk_sys) dma_mode <= 1;
        tick(0);
        chk(dma_req, 1);
        @(posedge clk_sys) dma_wr <= 1;
        tick(70);
        dma_wr <= 0;
        chk({1'b0, cpu_count}, 8'h40);
        chk(dma_req, 0);
        tick(3);
        chk(bulk_in_nak_ctrl, 0);
        @(posedge clk_sys) bulk_in_data_end_set <= 1;
        @(posedge clk_sys) bulk_in_data_end_set <= 0;
        tick(1);
        chk(bulk_in_nak_ctrl, 1);
        chk(dma_req, 1);
        @(posedge clk_sys) dma_terminal_count <= 1;
        @(posedge clk_sys) dma_terminal_count <= 0;
        tick(1);
        chk(dma_req, 0);
        @(posedge clk_sys) dma_unmask <= 1;
        @(posedge clk_sys) dma_unmask <= 0;
        tick(1);
        chk(dma_req, 1);
        @(posedge clk_sys) buf_clear <= 1;
        @(posedge clk_sys) buf_clear <= 0;
        dma_mode <= 0;
        tick(0);
        chk(bulk_in_nak_ctrl, 0);
        $display("dma done");
    endtask
    task automatic t_bus;
        @(posedge clk_sys) configured_set <= 1;
        alt_setting_wr <= 1;
        alt_setting_wr_data <= 8'h5a;
        @(posedge clk_sys) {configured_set, alt_setting_wr} <= 2'h0;
        tick(1);
        chk(device_state_reg, 8'h04);
        chk(alt_setting_status_reg, 8'h5a);
        @(posedge clk_sys) bus_reset <= 1;
        @(posedge clk_sys) bus_reset <= 0;
        tick(1);
        chk(device_state_reg, 8'h00);
        chk(alt_setting_status_reg, 8'h00);
        chk(interrupt_clear_reg_first, 8'hff);
        @(posedge clk_sys) configured_set <= 1;
        alt_setting_wr <= 1;
        @(posedge clk_sys) {configured_set, alt_setting_wr} <= 2'h0;
        @(posedge clk_sys) reset <= 1;
        @(posedge clk_sys) reset <= 0;
        tick(1);
        chk(device_state_reg, 8'h00);
        chk(alt_setting_status_reg, 8'h00);
        chk(interrupt_clear_reg_first, 8'hff);
        $display("bus reset done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 0;
        tick(1);
        chk(bulk_in_nak_ctrl, 0);
        chk(interrupt_clear_reg_first, 8'hff);
        chk(device_state_reg, 8'h00);
        t_pio();
        t_short();
        t_dma();
        t_bus();
        print_verdict();
    end
    initial begin
        #1000000;
        err_count++;
        print_verdict();
    end
endmodule
